// File: bench/aspmc_ctrl_tb.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module aspmc_ctrl_tb;
	logic        clk;                  // 250 mhz system clock
	logic        rstn;                 // async reset, active low
	logic        sclk;                 // link clock from the host model
	logic        cs_n;                 // select from the host model
	logic        dat_a, oe_n_a, dat_b, oe_n_b;
	logic        cfg, rng;             // input configuration and range pins
	logic [2:0]  addr;                 // channel address pins
	logic [11:0] code_a, code_b;       // raw core results
	logic        hold, start, abort, aon, ron, ready;
	logic [1:0]  state, scale;
	int          fail_count, comparisons, cycles, abort_cnt, start_cnt;
	////////////////////////////////////////////////////////////////////////////
	// short full power-up count keeps the run brief
	aspmc_ctrl #(.PUP_FULL_CYC(50)) aspmc_ctrl_inst (
		.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
		.data_out_a(dat_a), .data_out_a_oe_n(oe_n_a),
		.data_out_b(dat_b), .data_out_b_oe_n(oe_n_b),
		.input_config_select(cfg), .range_sel(rng), .channel_addr(addr),
		.sar_code_a(code_a), .sar_code_b(code_b), .sample_hold(hold),
		.conv_start(start), .conv_abort(abort), .analog_on(aon), .ref_on(ron),
		.pwr_ready(ready), .pwr_state(state), .lsb_scale(scale));
	aspmc_host_model aspmc_host_model_inst (
		.sclk(sclk), .cs_n(cs_n), .data_out_a(dat_a), .data_out_a_oe_n(oe_n_a),
		.data_out_b(dat_b), .data_out_b_oe_n(oe_n_b), .sample_hold(hold));
	////////////////////////////////////////////////////////////////////////////
	// clock, pulse counters and hang guard
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (abort === 1'b1) abort_cnt++;
		if (start === 1'b1) start_cnt++;
		// about 21k cycles expected; well past that means a hang
		if (cycles == 90000) begin
			fail_count++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask
	// expected line content: two leading zeros, result msb first, zeros, other result
	function automatic logic [32:0] stream(input logic [11:0] c1, input logic [11:0] c2);
		logic [32:0] s;
		s = '0;
		for (int j = 0; j < 12; j++) begin
			s[2+j]  = c1[11-j];
			s[18+j] = c2[11-j];
		end
		return s;
	endfunction
	// twos complement output is the raw offset code with its msb turned over
	function automatic logic [11:0] cod(input logic [11:0] c, input logic inv);
		return inv ? {~c[11], c[10:0]} : c;
	endfunction
	task automatic set_pins(input logic c, input logic r, input logic [2:0] a,
			input logic [11:0] ca, input logic [11:0] cb);
		@(posedge clk);
		cfg    <= c;
		rng    <= r;
		addr   <= a;
		code_a <= ca;
		code_b <= cb;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// dual read on both lines with the bus released at the 32nd edge
	task automatic t_dual_read();
		set_pins(1'b1, 1'b0, 3'h0, 12'hA5C, 12'h3B1);
		aspmc_host_model_inst.frame(16); // settles the coding flops
		aspmc_host_model_inst.frame(33);
		chk(aspmc_host_model_inst.bits_a[31:0], stream(12'hA5C, 12'h3B1), "line a");
		chk(aspmc_host_model_inst.bits_b[31:0], stream(12'h3B1, 12'hA5C), "line b");
		chk(aspmc_host_model_inst.oe_a, 33'h100000000, "line a enable");
		chk(aspmc_host_model_inst.oe_b, 33'h100000000, "line b enable");
		chk({aspmc_host_model_inst.hold[14:13], aspmc_host_model_inst.hold[0]}, 33'h3, "hold");
	endtask
	////////////////////////////////////////////////////////////////////////////
	// every configuration and range: coding of the first field and lsb scale
	task automatic t_coding();
		// config, range, expected twos complement
		logic [4:0] tbl [5] = '{5'b10000, 5'b11100, 5'b00100, 5'b01100, 5'b00000};
		logic [2:0] tba [5] = '{3'h0, 3'h2, 3'h4, 3'h0, 3'h1};
		logic [1:0] tsc [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0};
		for (int i = 0; i < 5; i++) begin
			set_pins(tbl[i][4], tbl[i][3], tba[i], 12'h812, 12'h07E);
			aspmc_host_model_inst.frame(16);
			aspmc_host_model_inst.frame(16);
			chk(aspmc_host_model_inst.bits_a[15:0],
				stream(cod(12'h812, tbl[i][2]), 12'h000) & 33'hFFFF, "coding");
			chk(scale, tsc[i], "lsb scale");
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	// one frame of n edges, then state, pulses and released lines
	task automatic pframe(input int n, input logic [1:0] st);
		int a0, s0;
		a0 = abort_cnt;
		s0 = start_cnt;
		aspmc_host_model_inst.frame(n);
		chk(state, st, "power state");
		chk(start_cnt - s0, 33'h1, "start pulse");
		chk(abort_cnt - a0, (n < 14) ? 33'h1 : 33'h0, "abort pulse");
		chk({oe_n_a, oe_n_b}, 33'h3, "lines released");
	endtask
	task automatic t_power();
		pframe(1, aspmc_pkg::PWR_NORMAL);
		pframe(5, aspmc_pkg::PWR_PARTIAL);
		chk({aon, ron, ready}, 33'h2, "partial analog off");
		pframe(1, aspmc_pkg::PWR_PARTIAL);
		pframe(5, aspmc_pkg::PWR_FULL);
		chk({ron, ready}, 33'h0, "full reference off");
		pframe(12, aspmc_pkg::PWR_NORMAL);
		chk({aon, ron, ready}, 33'h7, "full power-up");
		pframe(9, aspmc_pkg::PWR_PARTIAL);
		pframe(10, aspmc_pkg::PWR_NORMAL);
		chk(ready, 33'h1, "partial power-up");
		pframe(14, aspmc_pkg::PWR_NORMAL);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// reset for eight cycles, then the scenarios in turn
	initial begin
		fail_count  = 0;
		comparisons = 0;
		cycles      = 0;
		abort_cnt   = 0;
		start_cnt   = 0;
		rstn        = 1'b0;
		cfg         = 1'b1;
		rng         = 1'b0;
		addr        = 3'h0;
		code_a      = 12'h000;
		code_b      = 12'h000;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		chk({state, ready}, 33'h1, "reset state");
		t_dual_read();
		t_coding();
		set_pins(1'b1, 1'b0, 3'h0, 12'h555, 12'hAAA);
		t_power();
		test_done();
	end
endmodule

// File: bench/aspmc_host_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// host serial port: drives select and a gated link clock, samples both lines
module aspmc_host_model (
	// link toward the converter
	output logic        sclk,
	output logic        cs_n,
	// data lines and their enables
	input  wire logic   data_out_a,
	input  wire logic   data_out_a_oe_n,
	input  wire logic   data_out_b,
	input  wire logic   data_out_b_oe_n,
	// hold indication from the sampler
	input  wire logic   sample_hold
);
	logic [32:0] bits_a;    // line a, one entry per falling edge count
	logic [32:0] bits_b;    // line b, same indexing
	logic [32:0] oe_a;      // enable of line a after each edge
	logic [32:0] oe_b;      // enable of line b after each edge
	logic [32:0] hold;      // sampler state after each edge
	////////////////////////////////////////////////////////////////////////////
	// link clock idles high and stands still between frames
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////
	// capture everything mid-way between a falling edge and the next rising edge, where data is settled
	task automatic grab(input int k);
		if (k <= 32) begin
			// a released line has no pull, so it reads as the inverse of its last bit
			bits_a[k] = data_out_a_oe_n ? ~data_out_a : data_out_a;
			bits_b[k] = data_out_b_oe_n ? ~data_out_b : data_out_b;
			oe_a[k]   = data_out_a_oe_n;
			oe_b[k]   = data_out_b_oe_n;
			hold[k]   = sample_hold;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	// one frame of n falling edges; the host keeps its own edge count
	task automatic frame(input int n);
		int k;
		bits_a = '0;
		bits_b = '0;
		oe_a   = '1;
		oe_b   = '1;
		hold   = '0;
		// keep link edges off the system clock's edges; the two clocks share no phase
		#1;
		cs_n   = 1'b0; // sampling starts here
		// first fall kept well clear of select fall so the count is not missed
		#60;
		grab(0);
		for (k = 1; k <= n; k++) begin // select held low for n edges
			sclk = 1'b0;
			#40;
			grab(k);
			#40;
			sclk = 1'b1;
			#80;
		end
		#40;
		cs_n = 1'b1;
		// quiet and acquisition time before any new frame
		#1999;
	endtask
endmodule

// File: core/aspmc_ctrl.sv
`timescale 1ns/100ps
`include "aspmc_params.svh"
// Functional notes
// - codes step one LSB; LSB scales with mode
// - select fall starts conversion, restarts edge count
// - rise in 10..13 aborts, floats, stays powered
// - fourteen clocks give one full result
// - after fourteen edges keep driving the output
// - two trailing zeros follow the result
// - other converter result follows on same line
// - float at 32nd edge or select rise
// - normal: rise in 2..9 gives partial down
// - normal: rise before edge two keeps normal
// - dummy conversion past ten edges powers up
// - partial: early rise stays partial down
// - partial: rise in 2..9 gives full down
// - twos complement unless single range unipolar
// - two leading zeros, last bit on 14th
// - track resumes on rising edge after 13
module aspmc_ctrl #(
	parameter int unsigned        PUP_FULL_CYC = `ASPMC_PUP_FULL_CYC
) (
	// system clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// serial link from the host
	input  wire logic             sclk,
	input  wire logic             cs_n,
	output logic                  data_out_a,
	output logic                  data_out_a_oe_n,
	output logic                  data_out_b,
	output logic                  data_out_b_oe_n,
	// configuration pins
	input  wire logic             input_config_select,
	input  wire logic             range_sel,
	input  wire logic [2:0]       channel_addr,
	// converter core, sclk domain
	input  wire logic [11:0]      sar_code_a,
	input  wire logic [11:0]      sar_code_b,
	output logic                  sample_hold,
	// status toward the analog side
	output logic                  conv_start,
	output logic                  conv_abort,
	output logic                  analog_on,
	output logic                  ref_on,
	output logic                  pwr_ready,
	output logic [1:0]            pwr_state,
	output logic [1:0]            lsb_scale
);
	////////////////////////////////////////////////////////////////////////////////
	// link domain: falling-edge counter and serializer

	logic                         link_rst_n;  // reset while select is high
	logic [`ASPMC_CNT_W-1:0]      cnt_q;       // edges in this frame
	logic [`ASPMC_CNT_W-1:0]      cnt_d;
	logic                         fresh_q;     // no edge yet in this frame
	logic [`ASPMC_CNT_W-1:0]      edge_q;      // free-running edge total
	logic [`ASPMC_CNT_W-1:0]      edge_gray_q; // gray copy for the crossing
	logic [`ASPMC_CNT_W-1:0]      edge_nx;
	logic [11:0]                  res_a_q;     // coded result a
	logic [11:0]                  res_b_q;     // coded result b
	logic                         twos_q;      // coding level, system side
	logic                         tw_lvl;      // coding level seen by the link
	logic                         dout_a_q;
	logic                         dout_b_q;
	logic                         done_q;      // line released after 32
	logic                         track_q;     // back in track
	logic [3:0]                   slot;        // position in a 16-edge field
	logic [3:0]                   bidx;        // result bit for that slot
	logic                         in_data;
	logic                         second;      // second field: other result
	logic                         bit_a;
	logic                         bit_b;

	assign link_rst_n = rstn & ~cs_n;

	// saturating count, restarted by the first edge after select falls
	assign cnt_d = fresh_q ? `ASPMC_CNT_ONE :
		((cnt_q == `ASPMC_CNT_MAX) ? cnt_q : cnt_q + `ASPMC_CNT_ONE);
	assign edge_nx = edge_q + `ASPMC_CNT_ONE;

	// slot decode for the bit that appears after this edge
	assign slot    = cnt_d[3:0];
	assign second  = cnt_d[4];
	assign in_data = (slot >= `ASPMC_SLOT_FIRST) && (slot <= `ASPMC_SLOT_LAST)
		&& !cnt_d[5];
	assign bidx    = `ASPMC_SLOT_LAST - slot;
	// leading and trailing slots read as zero
	assign bit_a   = in_data & (second ? res_b_q[bidx] : res_a_q[bidx]);
	assign bit_b   = in_data & (second ? res_a_q[bidx] : res_b_q[bidx]);

	// counters keep their value after select rises so the system side can read them
	always_ff @(negedge sclk or negedge rstn) begin
		if (!rstn) begin
			cnt_q       <= '0;
			edge_q      <= '0;
			edge_gray_q <= '0;
		end else if (!cs_n) begin
			cnt_q       <= cnt_d;
			edge_q      <= edge_nx;
			edge_gray_q <= edge_nx ^ (edge_nx >> 1);
		end
	end

	// coding level crossing into the link; sclk stops between frames, so
	// a pin change reaches the data only after four rising edges have run
	aspmc_pin_sync #(.W (1), .RST_VAL (1'h0)) u_twos (
		.clk   (sclk),
		.rstn  (rstn),
		.pin_i (twos_q),
		.lvl_o (tw_lvl)
	);

	// results taken at the first edge; the core delivers offset binary,
	// so twos complement is the inverted msb
	always_ff @(negedge sclk or negedge rstn) begin
		if (!rstn) begin
			res_a_q <= '0;
			res_b_q <= '0;
		end else if (!cs_n && fresh_q) begin
			res_a_q <= {sar_code_a[11] ^ tw_lvl, sar_code_a[10:0]};
			res_b_q <= {sar_code_b[11] ^ tw_lvl, sar_code_b[10:0]};
		end
	end

	// frame state; select high gives the first leading zero, release holds to select rise
	always_ff @(negedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			fresh_q  <= 1'h1;
			dout_a_q <= 1'h0;
			dout_b_q <= 1'h0;
			done_q   <= 1'h0;
		end else begin
			fresh_q  <= 1'h0;
			dout_a_q <= bit_a;
			dout_b_q <= bit_b;
			done_q   <= done_q | (cnt_d >= `ASPMC_EDGE_END);
		end
	end

	// track resumes on the rising edge that follows edge 13
	always_ff @(posedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			track_q <= 1'h0;
		end else if (!fresh_q && cnt_q >= `ASPMC_EDGE_TRACK) begin
			track_q <= 1'h1;
		end
	end

	// select rise floats both lines at once, also when aborting
	assign data_out_a      = dout_a_q;
	assign data_out_b      = dout_b_q;
	assign data_out_a_oe_n = cs_n | done_q;
	assign data_out_b_oe_n = cs_n | done_q;
	assign sample_hold     = ~cs_n & ~track_q;

	////////////////////////////////////////////////////////////////////////////////
	// system domain: pin sync and edge-count crossing

	logic [5:0]                   pins_s;      // cs, config, range, addr
	logic [`ASPMC_CNT_W-1:0]      gray_s;
	logic [`ASPMC_CNT_W-1:0]      edge_bin;
	logic [`ASPMC_CNT_W-1:0]      edge_prev_q;
	logic [`ASPMC_CNT_W-1:0]      fr_n_q;      // edges seen this frame
	logic                         cs_low;
	logic                         cs_low_q;
	logic                         cs_fall;
	logic                         cs_rise;
	logic                         fully_diff;

	aspmc_pin_sync #(
		.W       (6),
		.RST_VAL (6'h20)
	) u_pins (
		.clk   (clk),
		.rstn  (rstn),
		.pin_i ({cs_n, input_config_select, range_sel, channel_addr}),
		.lvl_o (pins_s)
	);

	aspmc_word_sync #(
		.W (`ASPMC_CNT_W)
	) u_edge (
		.clk    (clk),
		.rstn   (rstn),
		.gray_i (edge_gray_q),
		.gray_o (gray_s)
	);

	// gray back to binary, one prefix xor per bit
	genvar gi;
	generate
		for (gi = 0; gi < `ASPMC_CNT_W; gi++) begin : g_g2b
			assign edge_bin[gi] = ^gray_s[`ASPMC_CNT_W-1:gi];
		end
	endgenerate

	assign cs_low     = ~pins_s[5];
	assign cs_fall    = cs_low & ~cs_low_q;
	assign cs_rise    = ~cs_low & cs_low_q;
	assign fully_diff = ~pins_s[4] & ~pins_s[0];

	// frame edge count seen from here; an edge inside the few cycles of
	// select-fall detection is missed, harmless at the link clock rate
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cs_low_q    <= 1'h0;
			edge_prev_q <= '0;
			fr_n_q      <= '0;
		end else begin
			cs_low_q    <= cs_low;
			edge_prev_q <= edge_bin;
			if (cs_fall) begin
				fr_n_q <= '0;
			end else if (cs_low && edge_bin != edge_prev_q
				&& fr_n_q != `ASPMC_EDGE_END) begin
				fr_n_q <= fr_n_q + `ASPMC_CNT_ONE;
			end
		end
	end

	// coding and lsb size from the configuration pins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			twos_q    <= 1'h0;
			lsb_scale <= 2'h0;
		end else begin
			twos_q    <= pins_s[3] | fully_diff;
			lsb_scale <= {1'h0, fully_diff} + {1'h0, pins_s[3]};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// power state machine

	aspmc_pkg::aspmc_pwr_t        pwr_q;
	aspmc_pkg::aspmc_pwr_t        pwr_d;
	logic [`ASPMC_TMR_W-1:0]      tmr_q;       // power-up wait
	logic                         n_ge2;
	logic                         n_ge10;
	logic                         n_ge14;

	assign n_ge2  = fr_n_q >= `ASPMC_EDGE_GLITCH;
	assign n_ge10 = fr_n_q >= `ASPMC_EDGE_AWAKE;
	assign n_ge14 = fr_n_q >= `ASPMC_EDGE_RESULT;

	// next state, decided at select rise by the count and the current state
	always_comb begin
		pwr_d = pwr_q;
		if (cs_rise) begin
			if (n_ge10) begin
				pwr_d = aspmc_pkg::PWR_NORMAL;
			end else if (n_ge2) begin
				case (pwr_q)
					aspmc_pkg::PWR_NORMAL: begin
						pwr_d = aspmc_pkg::PWR_PARTIAL;
					end
					aspmc_pkg::PWR_PARTIAL: begin
						pwr_d = aspmc_pkg::PWR_FULL;
					end
					aspmc_pkg::PWR_FULL: begin
						pwr_d = aspmc_pkg::PWR_FULL;
					end
					default: begin
						pwr_d = aspmc_pkg::PWR_NORMAL;
					end
				endcase
			end
			// a glitch shorter than two edges leaves any state as it was
		end
	end

	// state register and power-up timer; the timer runs from select fall
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pwr_q <= aspmc_pkg::PWR_NORMAL;
			tmr_q <= '0;
		end else begin
			pwr_q <= pwr_d;
			if (cs_fall && pwr_q == aspmc_pkg::PWR_FULL) begin
				tmr_q <= `ASPMC_TMR_W'(PUP_FULL_CYC);
			end else if (cs_fall && pwr_q == aspmc_pkg::PWR_PARTIAL) begin
				tmr_q <= `ASPMC_TMR_W'(`ASPMC_PUP_PARTIAL_CYC);
			end else if (cs_rise && !n_ge10) begin
				tmr_q <= '0;
			end else if (tmr_q != '0) begin
				tmr_q <= tmr_q - `ASPMC_TMR_W'(1);
			end
		end
	end

	// event pulses and status levels
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			conv_start <= 1'h0;
			conv_abort <= 1'h0;
			pwr_ready  <= 1'h0;
		end else begin
			conv_start <= cs_fall;
			conv_abort <= cs_rise & ~n_ge14;
			pwr_ready  <= (pwr_d == aspmc_pkg::PWR_NORMAL) && (tmr_q == '0);
		end
	end

	// powering during any frame; reference stays up in partial down
	assign analog_on = (pwr_q == aspmc_pkg::PWR_NORMAL) | cs_low;
	assign ref_on    = (pwr_q != aspmc_pkg::PWR_FULL);
	assign pwr_state = pwr_q;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	a_lead_zero: assert property (@(negedge sclk) disable iff (!link_rst_n)
		fresh_q |-> !data_out_a && !data_out_b)
		else $error("leading zero missing");
	a_trail_zero: assert property (@(negedge sclk) disable iff (!link_rst_n)
		!fresh_q && (cnt_q == 6'h0E || cnt_q == 6'h0F) |-> !data_out_a)
		else $error("trailing zero missing");
	a_second_result: assert property (@(negedge sclk) disable iff (!link_rst_n)
		!fresh_q && cnt_q == 6'h12 |-> data_out_a == res_b_q[11])
		else $error("second result msb wrong");
	a_drive_after_14: assert property (@(negedge sclk) disable iff (!link_rst_n)
		!fresh_q && cnt_q >= 6'h0E && cnt_q < 6'h20 |-> !data_out_a_oe_n)
		else $error("line floated before edge 32");
	a_float_at_32: assert property (@(negedge sclk) disable iff (!link_rst_n)
		!fresh_q && cnt_q == 6'h20 |-> data_out_a_oe_n && data_out_b_oe_n)
		else $error("line not floated at edge 32");
	a_track_return: assert property (@(posedge sclk) disable iff (!link_rst_n)
		!fresh_q && cnt_q == 6'h0D |=> track_q && !sample_hold)
		else $error("track not resumed");

	a_partial_entry: assert property (@(posedge clk) disable iff (!rstn)
		cs_rise && pwr_q == aspmc_pkg::PWR_NORMAL && n_ge2 && !n_ge10
		|=> pwr_q == aspmc_pkg::PWR_PARTIAL ##1 conv_abort == 1'h0)
		else $error("partial power-down not entered");

	a_full_entry: assert property (@(posedge clk) disable iff (!rstn)
		cs_rise && pwr_q == aspmc_pkg::PWR_PARTIAL && n_ge2 && !n_ge10
		|=> pwr_q == aspmc_pkg::PWR_FULL && !ref_on)
		else $error("full power-down not entered");

	a_glitch_keeps: assert property (@(posedge clk) disable iff (!rstn)
		cs_rise && !n_ge2 |=> $stable(pwr_q))
		else $error("select glitch changed power state");

	a_awake_abort: assert property (@(posedge clk) disable iff (!rstn)
		cs_rise && n_ge10 && !n_ge14 |=> pwr_q == aspmc_pkg::PWR_NORMAL && conv_abort)
		else $error("abort after edge 10 wrong");

	a_state_hold: assert property (@(posedge clk) disable iff (!rstn)
		!cs_rise |=> pwr_q == $past(pwr_q))
		else $error("power state moved without select rise");

	c_dual_read: cover property (@(negedge sclk) disable iff (!link_rst_n)
		cnt_q == 6'h20);
	c_partial: cover property (@(posedge clk) disable iff (!rstn)
		pwr_q == aspmc_pkg::PWR_PARTIAL);
	c_full: cover property (@(posedge clk) disable iff (!rstn)
		pwr_q == aspmc_pkg::PWR_FULL);
	c_wake: cover property (@(posedge clk) disable iff (!rstn)
		pwr_q == aspmc_pkg::PWR_FULL ##1 pwr_q == aspmc_pkg::PWR_NORMAL);
endmodule

// File: core/aspmc_pin_sync.sv
`timescale 1ns/100ps
// three-stage pin synchroniser; a change is taken once stages two and three agree
module aspmc_pin_sync #(
	parameter int unsigned     W       = 1,
	parameter logic [W-1:0]    RST_VAL = '0
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rstn,
	// pins and qualified levels
	input  wire logic [W-1:0]  pin_i,
	output logic [W-1:0]       lvl_o
);
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			logic s1_q;       // metastable stage, read by s2 only
			logic s2_q;
			logic s3_q;
			logic lvl_q;      // filtered level
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					s1_q  <= RST_VAL[gi];
					s2_q  <= RST_VAL[gi];
					s3_q  <= RST_VAL[gi];
					lvl_q <= RST_VAL[gi];
				end else begin
					s1_q <= pin_i[gi];
					s2_q <= s1_q;
					s3_q <= s2_q;
					// one-cycle glitches on the pin never reach the level
					if (s2_q == s3_q) begin
						lvl_q <= s3_q;
					end
				end
			end
			assign lvl_o[gi] = lvl_q;
		end
	endgenerate
endmodule

// File: core/aspmc_word_sync.sv
`timescale 1ns/100ps
// three-stage synchroniser for a gray-coded word; only one bit moves per step,
// and a bit is taken once stages two and three agree
module aspmc_word_sync #(
	parameter int unsigned     W = 6
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rstn,
	// word from the other domain and its local copy
	input  wire logic [W-1:0]  gray_i,
	output logic [W-1:0]       gray_o
);
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			logic s1_q;   // first stage, read by s2 only
			logic s2_q;
			logic s3_q;
			logic lvl_q;  // agreed bit handed to the local side
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					s1_q  <= 1'h0;
					s2_q  <= 1'h0;
					s3_q  <= 1'h0;
					lvl_q <= 1'h0;
				end else begin
					s1_q <= gray_i[gi];
					s2_q <= s1_q;
					s3_q <= s2_q;
					// a bit caught mid-change is held back one more cycle
					if (s2_q == s3_q) begin
						lvl_q <= s3_q;
					end
				end
			end
			assign gray_o[gi] = lvl_q;
		end
	endgenerate
endmodule

// File: inc/aspmc_params.svh
`ifndef ASPMC_PARAMS_SVH
`define ASPMC_PARAMS_SVH
// result and counter widths
`define ASPMC_CODE_W 12
`define ASPMC_CNT_W 6
// falling-edge counts within one select-low frame
`define ASPMC_EDGE_GLITCH 6'h02
`define ASPMC_EDGE_AWAKE 6'h0A
`define ASPMC_EDGE_TRACK 6'h0D
`define ASPMC_EDGE_RESULT 6'h0E
`define ASPMC_EDGE_END 6'h20
`define ASPMC_CNT_MAX 6'h3F
`define ASPMC_CNT_ONE 6'h01
// bit slots inside one 16-edge result field
`define ASPMC_SLOT_FIRST 4'h2
`define ASPMC_SLOT_LAST 4'hD
// power-up times and their clock counts
`define ASPMC_CLK_PERIOD_PS 4000
`define ASPMC_PUP_PARTIAL_NS 1000
`define ASPMC_PUP_FULL_US 1500
`define ASPMC_PUP_PARTIAL_CYC ((`ASPMC_PUP_PARTIAL_NS * 1000 + `ASPMC_CLK_PERIOD_PS - 1) / `ASPMC_CLK_PERIOD_PS)
`define ASPMC_PUP_FULL_CYC ((`ASPMC_PUP_FULL_US * 1000000 + `ASPMC_CLK_PERIOD_PS - 1) / `ASPMC_CLK_PERIOD_PS)
`define ASPMC_TMR_W 19
`endif

// File: inc/aspmc_pkg.sv
package aspmc_pkg;
	// power state of the converter
	typedef enum logic [1:0] {
		PWR_NORMAL,
		PWR_PARTIAL,
		PWR_FULL
	} aspmc_pwr_t;
endpackage
